// *** rtl/clk_sel_map.vh ***
/*
 * Constants for the CPU clock selector and oscillator watchdog.
 * Assumes inclusion by the single design file of this block.
 */
`ifndef CLK_SEL_MAP_VH
`define CLK_SEL_MAP_VH
`define CFG_X4       3'h7
`define CFG_X3       3'h6
`define CFG_X2       3'h5
`define CFG_X5       3'h4
`define CFG_DIRECT   3'h3
`define CFG_X1P5     3'h2
`define CFG_PRESCALE 3'h1
`define CFG_X2P5     3'h0
`define CFG_RESET    3'h7
`define FACTOR_X2_RESET 4'h8
`define SYSCFG_OWD_DIS_BIT 4
`define OWD_OVF_COUNT 5'h10
`define PLL_MODE_DIRECT   2'h0
`define PLL_MODE_PRESCALE 2'h1
`define PLL_MODE_MULT     2'h2
`define PLL_MODE_FAIL     2'h3
`endif

// *** rtl/cpu_clock_select.v ***
/*
 * CPU clock source selection with oscillator watchdog, modelled at the
 * sample level: CORE_CLK stands for the free-running PLL clock and the
 * crystal input is sampled on it. Assumes the analog PLL sits outside
 * and produces the multiplied clock; this block tells it the factor.
 */
`include "clk_sel_map.vh"
`default_nettype none

module cpu_clock_select (
    input  wire       CORE_CLK,
    input  wire       RESET,
    input  wire [2:0] CLOCK_CONFIG_PINS,
    input  wire       CRYSTAL_INPUT_PIN,
    input  wire [7:0] SYSTEM_CONFIG_REGISTER,
    output reg  [2:0] CLOCK_CONFIG_CODE,
    output reg  [1:0] CLOCK_MODE,
    output reg  [3:0] PLL_FACTOR_X2,
    output reg        PLL_ENABLE,
    output reg        CPU_CLOCK,
    output reg        CPU_CLOCK_RISE,
    output reg        CPU_CLOCK_FALL,
    output reg        PLL_RESYNC,
    output reg        OSC_FAIL_INTERRUPT_REQUEST,
    output reg  [4:0] WATCHDOG_COUNT
);

    // Factor times two so that 1.5 and 2.5 stay integral
    function [3:0] factor_x2;
        input [2:0] code;
        begin
            case (code)
                `CFG_X4:   factor_x2 = 4'h8;
                `CFG_X3:   factor_x2 = 4'h6;
                `CFG_X2:   factor_x2 = 4'h4;
                `CFG_X5:   factor_x2 = 4'ha;
                `CFG_X1P5: factor_x2 = 4'h3;
                `CFG_X2P5: factor_x2 = 4'h5;
                default:   factor_x2 = 4'h2;
            endcase
        end
    endfunction

    // Direct drive and prescaler are the modes that run without the multiplier
    function direct_class;
        input [2:0] code;
        begin
            direct_class = (code == `CFG_DIRECT) || (code == `CFG_PRESCALE);
        end
    endfunction

    localparam [1:0] ST_DIRECT   = `PLL_MODE_DIRECT;
    localparam [1:0] ST_PRESCALE = `PLL_MODE_PRESCALE;
    localparam [1:0] ST_MULT     = `PLL_MODE_MULT;
    localparam [1:0] ST_FAIL     = `PLL_MODE_FAIL;

    reg  [2:0] code_r;
    reg        xtal_d_r;
    reg        failed_r;
    reg  [3:0] edge_cnt_r;
    reg  [3:0] edge_cnt_nxt;
    reg        resync_nxt;
    reg        cpu_clk_nxt;
    reg  [4:0] cnt_nxt;
    reg  [1:0] mode_nxt;

    wire       owd_dis     = SYSTEM_CONFIG_REGISTER[`SYSCFG_OWD_DIS_BIT];
    wire       xtal_edge   = CRYSTAL_INPUT_PIN ^ xtal_d_r;
    wire       xtal_rise   = xtal_edge & CRYSTAL_INPUT_PIN;
    wire       mode_direct = (code_r == `CFG_DIRECT);
    wire       mode_pres   = (code_r == `CFG_PRESCALE);
    wire       supervise   = direct_class(code_r) & ~owd_dis;
    wire       overflow    = supervise & ~failed_r & ~xtal_edge &
                             (WATCHDOG_COUNT == `OWD_OVF_COUNT - 5'h01);
    wire       on_pll      = failed_r | overflow;
    wire [3:0] fac         = factor_x2(code_r);
    // Fractional factors round up, so 1.5 and 2.5 resync every 2nd and 3rd edge
    wire [3:0] resync_span = {1'b0, fac[3:1]} + {3'h0, fac[0]};

    // Config pins are only sampled while reset is held; the last value seen stays
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            code_r <= CLOCK_CONFIG_PINS;
        end
    end

    // Sampled in reset too, so a crystal already high gives no false edge at release
    always @(posedge CORE_CLK) begin
        xtal_d_r <= CRYSTAL_INPUT_PIN;
    end

    always @* begin
        cnt_nxt = WATCHDOG_COUNT;
        if (!supervise || failed_r) begin
            cnt_nxt = 5'h00;
        end else if (xtal_edge) begin
            cnt_nxt = 5'h00;
        end else if (WATCHDOG_COUNT != `OWD_OVF_COUNT) begin
            cnt_nxt = WATCHDOG_COUNT + 5'h01;
        end
    end

    // Sticky until hardware reset; a returning crystal never clears it
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            WATCHDOG_COUNT             <= 5'h00;
            failed_r                   <= 1'b0;
            OSC_FAIL_INTERRUPT_REQUEST <= 1'b0;
        end else begin
            WATCHDOG_COUNT <= cnt_nxt;
            if (overflow) begin
                failed_r                   <= 1'b1;
                OSC_FAIL_INTERRUPT_REQUEST <= 1'b1;
            end
        end
    end

    always @* begin
        cpu_clk_nxt = CPU_CLOCK;
        if (on_pll) begin
            cpu_clk_nxt = ~CPU_CLOCK;
        end else if (mode_direct) begin
            cpu_clk_nxt = CRYSTAL_INPUT_PIN;
        end else if (mode_pres) begin
            // Toggle on each rising input edge: each phase spans one input period
            if (xtal_rise) begin
                cpu_clk_nxt = ~CPU_CLOCK;
            end
        end else begin
            // Stand-in for the multiplied clock of the analog loop
            cpu_clk_nxt = ~CPU_CLOCK;
        end
    end

    always @(posedge CORE_CLK) begin
        if (RESET) begin
            CPU_CLOCK      <= 1'b0;
            CPU_CLOCK_RISE <= 1'b0;
            CPU_CLOCK_FALL <= 1'b0;
        end else begin
            CPU_CLOCK      <= cpu_clk_nxt;
            CPU_CLOCK_RISE <= cpu_clk_nxt & ~CPU_CLOCK;
            CPU_CLOCK_FALL <= ~cpu_clk_nxt & CPU_CLOCK;
        end
    end

    // Once failed over, only a reset leaves the fail state
    always @* begin
        mode_nxt = CLOCK_MODE;
        case (CLOCK_MODE)
            ST_FAIL: begin
                mode_nxt = ST_FAIL;
            end
            ST_DIRECT, ST_PRESCALE, ST_MULT: begin
                if (overflow) begin
                    mode_nxt = ST_FAIL;
                end else if (mode_direct) begin
                    mode_nxt = ST_DIRECT;
                end else if (mode_pres) begin
                    mode_nxt = ST_PRESCALE;
                end else begin
                    mode_nxt = ST_MULT;
                end
            end
            default: begin
                mode_nxt = ST_MULT;
            end
        endcase
    end

    always @(posedge CORE_CLK) begin
        if (RESET) begin
            CLOCK_MODE        <= ST_MULT;
            CLOCK_CONFIG_CODE <= `CFG_RESET;
            PLL_FACTOR_X2     <= `FACTOR_X2_RESET;
            PLL_ENABLE        <= 1'b0;
        end else begin
            CLOCK_MODE        <= mode_nxt;
            CLOCK_CONFIG_CODE <= code_r;
            PLL_FACTOR_X2     <= fac;
            // PLL runs free for the watchdog in direct modes, off when it is disabled
            PLL_ENABLE <= ~direct_class(code_r) | ~owd_dis | failed_r;
        end
    end

    always @* begin
        edge_cnt_nxt = edge_cnt_r;
        resync_nxt   = 1'b0;
        if (!direct_class(code_r) && xtal_edge) begin
            if (edge_cnt_r + 4'h1 >= resync_span) begin
                edge_cnt_nxt = 4'h0;
                resync_nxt   = 1'b1;
            end else begin
                edge_cnt_nxt = edge_cnt_r + 4'h1;
            end
        end
    end

    always @(posedge CORE_CLK) begin
        if (RESET) begin
            edge_cnt_r <= 4'h0;
            PLL_RESYNC <= 1'b0;
        end else begin
            edge_cnt_r <= edge_cnt_nxt;
            PLL_RESYNC <= resync_nxt;
        end
    end

endmodule // cpu_clock_select
`default_nettype wire

// *** tb/cpu_clock_select_props.sv ***
/* Port assertions for cpu_clock_select.
   Assumes it is bound into every instance of that module. */
`default_nettype none
module cpu_clock_select_props (
    input wire logic       CORE_CLK,
    input wire logic       RESET,
    input wire logic       CRYSTAL_INPUT_PIN,
    input wire logic       PLL_ENABLE,
    input wire logic       CPU_CLOCK,
    input wire logic       CPU_CLOCK_RISE,
    input wire logic       CPU_CLOCK_FALL,
    input wire logic       OSC_FAIL_INTERRUPT_REQUEST,
    input wire logic [7:0] SYSTEM_CONFIG_REGISTER,
    input wire logic [2:0] CLOCK_CONFIG_CODE,
    input wire logic [1:0] CLOCK_MODE,
    input wire logic [4:0] WATCHDOG_COUNT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    // The code output takes its latched value one edge after release, then holds
    code_hold_a:
    assert property (!$past(RESET) && !$past(RESET, 2) |-> $stable(CLOCK_CONFIG_CODE))
        else $error("code moved");
    count_clear_a:
    assert property (!CLOCK_MODE[1] && $changed(CRYSTAL_INPUT_PIN) |-> ##[0:1] WATCHDOG_COUNT == 5'h0)
        else $error("no clear");
    overflow_a:
    assert property ($rose(OSC_FAIL_INTERRUPT_REQUEST) |-> $past(WATCHDOG_COUNT) == 5'hf)
        else $error("overflow count");
    fail_sticky_a:
    assert property (OSC_FAIL_INTERRUPT_REQUEST |=> OSC_FAIL_INTERRUPT_REQUEST && CLOCK_MODE == 2'h3)
        else $error("fail dropped");
    pll_idle_a:
    assert property (CLOCK_MODE == 2'h2 |-> WATCHDOG_COUNT == 5'h0 && !OSC_FAIL_INTERRUPT_REQUEST)
        else $error("idle watchdog");
    pll_power_a:
    assert property (!$past(RESET) && !PLL_ENABLE |->
                     !CLOCK_MODE[1] && $past(SYSTEM_CONFIG_REGISTER[4]))
        else $error("pll off");
    edge_strobe_a:
    assert property (CPU_CLOCK_RISE == $rose(CPU_CLOCK) && CPU_CLOCK_FALL == $fell(CPU_CLOCK))
        else $error("strobe");
    fail_clock_a:
    assert property ($past(CLOCK_MODE) == 2'h3 && CLOCK_MODE == 2'h3 |-> $changed(CPU_CLOCK))
        else $error("fail clock");
    cover property ($rose(OSC_FAIL_INTERRUPT_REQUEST));
    cover property (CLOCK_MODE == 2'h1 && $changed(CPU_CLOCK));
    cover property (!PLL_ENABLE);
endmodule // cpu_clock_select_props
bind cpu_clock_select cpu_clock_select_props chk (
    .CORE_CLK(CORE_CLK), .RESET(RESET), .CRYSTAL_INPUT_PIN(CRYSTAL_INPUT_PIN),
    .PLL_ENABLE(PLL_ENABLE), .CPU_CLOCK(CPU_CLOCK), .CPU_CLOCK_RISE(CPU_CLOCK_RISE),
    .CPU_CLOCK_FALL(CPU_CLOCK_FALL), .SYSTEM_CONFIG_REGISTER(SYSTEM_CONFIG_REGISTER),
    .OSC_FAIL_INTERRUPT_REQUEST(OSC_FAIL_INTERRUPT_REQUEST), .CLOCK_MODE(CLOCK_MODE),
    .CLOCK_CONFIG_CODE(CLOCK_CONFIG_CODE), .WATCHDOG_COUNT(WATCHDOG_COUNT));
`default_nettype wire

// *** tb/tb_top.sv ***
/* Self-checking bench for cpu_clock_select.
   Assumes the crystal model runs at 4 core cycles per half period. */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0, rst = 1'b1, run = 1'b1, xtal, pll_en, cpu, rise, fall, resync, fail;
    logic [2:0] pins = 3'h7, code;
    logic [7:0] sys = 8'h00;
    logic [1:0] mode;
    logic [3:0] fx2;
    logic [4:0] cnt;
    int         n_errors = 0, checks = 0, n, m;
    int         fx[8] = '{5, 2, 3, 2, 10, 4, 6, 8};
    always #4 clk = ~clk;
    xtal_src src (.run(run), .xtal(xtal));
    cpu_clock_select uut (.CORE_CLK(clk), .RESET(rst), .CLOCK_CONFIG_PINS(pins),
        .CRYSTAL_INPUT_PIN(xtal), .SYSTEM_CONFIG_REGISTER(sys), .CLOCK_CONFIG_CODE(code),
        .CLOCK_MODE(mode), .PLL_FACTOR_X2(fx2), .PLL_ENABLE(pll_en), .CPU_CLOCK(cpu),
        .CPU_CLOCK_RISE(rise), .CPU_CLOCK_FALL(fall), .PLL_RESYNC(resync),
        .OSC_FAIL_INTERRUPT_REQUEST(fail), .WATCHDOG_COUNT(cnt));
    task end_of_test;
        if (n_errors == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task cmp(input string what, input int exp, input logic [7:0] got);
        checks++;
        if (got !== 8'(exp)) begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", what, 8'(exp), got);
        end
    endtask
    // Pins flip at release so a late latch would show up as a wrong code
    task rst_to(input int c, input int d);
        rst <= 1'b1;
        pins <= 3'(c);
        sys <= d ? 8'h10 : 8'h00;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        pins <= ~3'(c);
        repeat (2) @(posedge clk);
        #1;
    endtask
    // Cycles between two events: resync pulses, or CPU clock changes
    task gap(input bit rs);
        int i, k;
        logic p, e;
        k = 0;
        n = 0;
        p = cpu;
        for (i = 0; i < 300; i++) begin
            @(posedge clk);
            #1;
            e = rs ? resync === 1'b1 : cpu !== p;
            p = cpu;
            if (k) n++;
            if (e && k) break;
            if (e) k = 1;
        end
        if (i == 300) begin
            n_errors++;
            end_of_test;
        end
    endtask
    initial begin
        for (int c = 0; c < 8; c++) begin
            for (int d = 0; d < 2; d++) begin
                @(posedge clk);
                run <= 1'b1;
                rst_to(c, d);
                m = (c == 3) ? 0 : (c == 1) ? 1 : 2;
                cmp("code", c, code);
                cmp("mode", m, mode);
                cmp("factor", fx[c], fx2);
                cmp("pll_en", m == 2 || !d, pll_en);
                gap(m == 2);
                cmp("gap", m == 2 ? (fx[c] + 1) / 2 * 4 : m ? 8 : 4, n);
                cmp("live", 0, fail);
                @(posedge clk);
                run <= 1'b0;
                repeat (30) @(posedge clk);
                #1;
                cmp("fail", m < 2 && !d, fail);
                cmp("failmode", m < 2 && !d ? 3 : m, mode);
                if (m == 2 || d) cmp("count", 0, cnt);
                @(posedge clk);
                run <= 1'b1;
                repeat (20) @(posedge clk);
                #1;
                cmp("held", m < 2 && !d ? 3 : m, mode);
            end
        end
        end_of_test;
    end
endmodule // tb_top
`default_nettype wire

// *** tb/xtal_src.sv ***
/* External clock source model.
   Assumes run is driven by the bench; a stopped source sticks at its level. */
`default_nettype none
module xtal_src #(parameter int HALF_NS = 32) (
    input  wire logic run,
    output var  logic xtal
);
    timeunit 1ns;
    timeprecision 1ps;
    // Half period is a multiple of 8 ns, so toggles land on falling core edges
    initial xtal = 1'b0;
    always #(HALF_NS) if (run) xtal = ~xtal;
endmodule // xtal_src
`default_nettype wire
